//--- hdl/csrc_pkg.sv
package csrc_pkg;
	// ======================================================
	// register map (printed offsets are word indices)
	localparam logic [11:0] CTRL_INDEX = 12'h0D1;
	localparam logic [11:0] STAT_INDEX = 12'h0D2;
	localparam logic [11:0] CTRL_ADDR = {CTRL_INDEX[9:0], 2'b00};
	localparam logic [11:0] STAT_ADDR = {STAT_INDEX[9:0], 2'b00};
	localparam logic [7:0] CTRL_RESET = 8'h40;
	localparam int OSC_OFF_BIT = 2;
	// status register bit positions
	localparam int ST_BACKUP_BIT = 0;
	localparam int ST_GUARD_BIT = 1;
	localparam int ST_LVD_BIT = 2;
	localparam int ST_NMI_BIT = 3;
	localparam int ST_SEQ_LSB = 4;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	// ======================================================
	// core reset values
	localparam logic [11:0] RESET_VECTOR = 12'hFFE;
	localparam logic [11:0] DELAY_CYCLES = 12'h800;
	localparam logic [1:0] FETCH_CYCLES = 2'h2;

	// ======================================================
	// timing, 100 MHz system clock
	localparam int CLK_PERIOD_NS = 10;
	localparam int BACKUP_PERIOD_NS = 2500;
	localparam int MAIN_MISS_NS = 1000;
	localparam int GUARD_MIN_HI_NS = 125;
	localparam int GUARD_MIN_LO_NS = 250;
	// longest times round down, least times round up
	localparam logic [11:0] BACKUP_CYC =
		12'(BACKUP_PERIOD_NS / CLK_PERIOD_NS);
	localparam logic [11:0] MISS_CYC = 12'(MAIN_MISS_NS / CLK_PERIOD_NS);
	localparam logic [11:0] GUARD_HI_CYC =
		12'((GUARD_MIN_HI_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [11:0] GUARD_LO_CYC =
		12'((GUARD_MIN_LO_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	// ======================================================
	// types
	typedef enum logic [3:0] {
		SEQ_HOLD = 4'b0001,
		SEQ_DELAY = 4'b0010,
		SEQ_FETCH = 4'b0100,
		SEQ_RUN = 4'b1000
	} csrc_seq_t;

	typedef enum logic [2:0] {
		SRC_MAIN = 3'b001,
		SRC_WAIT = 3'b010,
		SRC_BACKUP = 3'b100
	} csrc_src_t;
endpackage : csrc_pkg

//--- hdl/csrc_top.sv
`timescale 1ns/1ps
// Notes on behaviour
// - guard filtering and backup clock exist only when the guard option is set
// - active guard drops main edges closer than the maximum authorised rate
// - low supply selects a longer minimum spacing, dropping extra cycles
// - backup oscillator may only run with the guard enabled
// - one backup period after a missing main edge, backup becomes internal clock
// - on backup the core keeps running, only with slower ticks
// - at power on backup clocks the delay until main starts, then main; here power on starts on main, backup only after a miss
// - backup stops as soon as main oscillator edges return
// - control bit 2 set disables main oscillator, clear enables it
// - main oscillator off bit ignored without the guard option
// - low-voltage reset acts only when its option is set
// - supply below threshold holds the device in static reset
// - rising threshold used while in reset, falling while running
// - low-voltage reset drives the reset pin low
// - reset sources: reset pin, watchdog, low-voltage detector
// - 2048 internal clock cycles of delay after any reset
// - vector fetch lasts exactly two internal clock cycles
// - reset clears the return stack and loads the vector address
// - reset enters NMI mode; return-from-interrupt leaves it
// - held in reset while pin low; short pulses stretched by delay
// - pin reset in run/wait stops code, pulls up ports, restarts oscillator
// - pin reset in stop starts oscillator and pulls up ports
// - watchdog reset restarts exactly like a pin reset
module csrc_top
	import csrc_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite slave
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// pins and option straps
	input wire logic main_osc_in,
	input wire logic reset_pin_in,
	output logic reset_pin_out,
	output logic reset_pin_oe,
	input wire logic guard_option,
	input wire logic lvd_option,
	input wire logic supply_high,
	input wire logic vdd_above_rising,
	input wire logic vdd_above_falling,
	// core side, same clock
	input wire logic watchdog_reset,
	input wire logic return_from_interrupt,
	output logic main_osc_en,
	output logic backup_low_freq_osc_run,
	output logic internal_clock,
	output logic core_reset,
	output logic stack_clear,
	output logic vector_fetch,
	output logic [11:0] pc_value,
	output logic nmi_mode,
	output logic io_pullup_inputs
);

	// ======================================================
	// state record
	typedef struct packed {
		logic [6:0] s1;
		logic [6:0] s2;
		logic osc_prev;
		csrc_src_t src;
		logic [11:0] gap_cnt;
		logic [11:0] miss_cnt;
		logic [11:0] bk_cnt;
		logic tick;
		logic lvd_below;
		logic pin_drive;
		csrc_seq_t seq;
		logic [11:0] dcnt;
		logic [1:0] fcnt;
		logic [11:0] pc;
		logic nmi;
		logic [7:0] ctrl;
		logic aw_ok;
		logic w_ok;
		logic [11:0] awaddr;
		logic [7:0] wbyte;
		logic wlane0;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} csrc_state_t;

	csrc_state_t cur_reg;
	csrc_state_t cur_next;

	// synchronised views: [0] osc, [1] reset pin, [2] guard, [3] lvd opt,
	// [4] supply, [5] rising cmp, [6] falling cmp
	logic osc_s, pin_n_s, guard_s, lvd_opt_s, sup_hi_s, above_r_s;
	logic above_f_s;
	logic osc_edge, osc_off_eff, req_any, lvd_rst;
	logic [11:0] min_gap;
	logic [31:0] stat_word;

	// ======================================================
	// address decoding shared by both channels
	function automatic logic [1:0] csrc_decode(input logic [11:0] a);
		if (a == CTRL_ADDR)
			csrc_decode = 2'b01;
		else if (a == STAT_ADDR)
			csrc_decode = 2'b10;
		else
			csrc_decode = 2'b00;
	endfunction : csrc_decode

	// without the guard the off bit is ignored entirely
	function automatic logic main_osc_off_hold();
		main_osc_off_hold = 1'b0;
	endfunction : main_osc_off_hold

	// second stage only; first stage feeds nothing else
	assign osc_s = cur_reg.s2[0];
	assign pin_n_s = cur_reg.s2[1];
	assign guard_s = cur_reg.s2[2];
	assign lvd_opt_s = cur_reg.s2[3];
	assign sup_hi_s = cur_reg.s2[4];
	assign above_r_s = cur_reg.s2[5];
	assign above_f_s = cur_reg.s2[6];

	// ======================================================
	// derived terms
	assign osc_edge = osc_s & ~cur_reg.osc_prev;
	// off bit only honoured under the guard option
	assign osc_off_eff = guard_s & cur_reg.ctrl[OSC_OFF_BIT];
	// longer spacing at low supply trims over-frequency
	assign min_gap = sup_hi_s ? GUARD_HI_CYC : GUARD_LO_CYC;
	assign lvd_rst = lvd_opt_s & cur_reg.lvd_below;
	// all three sources merge into one request
	assign req_any = ~pin_n_s | watchdog_reset | lvd_rst;

	// status word shows the block's own state
	always_comb
	begin
		stat_word = 32'h0000_0000;
		stat_word[ST_BACKUP_BIT] = (cur_reg.src == SRC_BACKUP);
		stat_word[ST_GUARD_BIT] = guard_s;
		stat_word[ST_LVD_BIT] = lvd_rst;
		stat_word[ST_NMI_BIT] = cur_reg.nmi;
		stat_word[ST_SEQ_LSB +: 4] = cur_reg.seq;
	end

	// ======================================================
	// next-state logic
	always_comb
	begin
		cur_next = cur_reg;
		cur_next.s1 = {vdd_above_falling, vdd_above_rising, supply_high,
			lvd_option,
			guard_option, reset_pin_in, main_osc_in};
		cur_next.s2 = cur_reg.s1;
		cur_next.osc_prev = osc_s;
		cur_next.tick = 1'b0;

		// clock guard and source selection
		if (cur_reg.gap_cnt != 12'hFFF)
			cur_next.gap_cnt = cur_reg.gap_cnt + 12'h001;
		if (!guard_s)
		begin
			// no guard: every main edge is a tick, no backup
			cur_next.src = SRC_MAIN;
			cur_next.tick = osc_edge & ~main_osc_off_hold();
			cur_next.miss_cnt = 12'h000;
		end
		else
		begin
			if (osc_edge && !osc_off_eff)
			begin
				cur_next.miss_cnt = 12'h000;
				// main back: backup shuts off at once
				cur_next.src = SRC_MAIN;
				if (cur_reg.gap_cnt >= min_gap)
				begin
					cur_next.tick = (cur_reg.src == SRC_MAIN);
					cur_next.gap_cnt = 12'h000;
				end
			end
			else
			begin
				case (cur_reg.src)
					SRC_MAIN:
					begin
						if (osc_off_eff || cur_reg.miss_cnt >= MISS_CYC)
						begin
							cur_next.src = SRC_WAIT;
							cur_next.bk_cnt = 12'h000;
						end
						else
							cur_next.miss_cnt = cur_reg.miss_cnt + 12'h001;
					end
					SRC_WAIT:
					begin
						// start one backup period after the miss
						if (cur_reg.bk_cnt >= BACKUP_CYC - 12'h001)
						begin
							cur_next.src = SRC_BACKUP;
							cur_next.bk_cnt = 12'h000;
						end
						else
							cur_next.bk_cnt = cur_reg.bk_cnt + 12'h001;
					end
					default:
					begin
						// slow ticks still drive core and sequencer
						if (cur_reg.bk_cnt >= BACKUP_CYC - 12'h001)
						begin
							cur_next.tick = 1'b1;
							cur_next.bk_cnt = 12'h000;
						end
						else
							cur_next.bk_cnt = cur_reg.bk_cnt + 12'h001;
					end
				endcase
			end
		end

		// low-voltage hysteresis: rising limit in reset, falling when running
		if (cur_reg.lvd_below)
			cur_next.lvd_below = ~above_r_s;
		else
			cur_next.lvd_below = ~above_f_s;
		cur_next.pin_drive = lvd_rst;

		// reset sequence
		case (cur_reg.seq)
			SEQ_HOLD:
			begin
				cur_next.dcnt = 12'h000;
				if (!req_any)
					cur_next.seq = SEQ_DELAY;
			end
			SEQ_DELAY:
			begin
				if (cur_reg.tick)
				begin
					cur_next.dcnt = cur_reg.dcnt + 12'h001;
					if (cur_reg.dcnt == DELAY_CYCLES - 12'h001)
					begin
						cur_next.seq = SEQ_FETCH;
						cur_next.fcnt = 2'h0;
					end
				end
			end
			SEQ_FETCH:
			begin
				cur_next.pc = RESET_VECTOR;
				if (cur_reg.tick)
				begin
					cur_next.fcnt = cur_reg.fcnt + 2'h1;
					if (cur_reg.fcnt == FETCH_CYCLES - 2'h1)
						cur_next.seq = SEQ_RUN;
				end
			end
			default:
			begin
				if (return_from_interrupt)
					cur_next.nmi = 1'b0;
			end
		endcase
		// any request restarts the whole sequence from zero
		if (req_any)
		begin
			cur_next.seq = SEQ_HOLD;
			cur_next.dcnt = 12'h000;
			cur_next.nmi = 1'b1;
			cur_next.pc = RESET_VECTOR;
			// reset value clears the off bit, restarting the oscillator
			cur_next.ctrl = CTRL_RESET;
		end

		// axi write channel
		if (s_axi_awvalid && s_axi_awready)
		begin
			cur_next.aw_ok = 1'b1;
			cur_next.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			cur_next.w_ok = 1'b1;
			cur_next.wbyte = s_axi_wdata[7:0];
			cur_next.wlane0 = s_axi_wstrb[0];
		end
		if (cur_reg.aw_ok && cur_reg.w_ok)
		begin
			cur_next.aw_ok = 1'b0;
			cur_next.w_ok = 1'b0;
			cur_next.bvalid = 1'b1;
			cur_next.bresp = RESP_OKAY;
			if (csrc_decode(cur_reg.awaddr) == 2'b01)
			begin
				if (cur_reg.wlane0 && !req_any)
					cur_next.ctrl = cur_reg.wbyte;
			end
			else if (csrc_decode(cur_reg.awaddr) == 2'b00)
				cur_next.bresp = RESP_SLVERR;
		end
		if (cur_reg.bvalid && s_axi_bready)
			cur_next.bvalid = 1'b0;

		// axi read channel
		if (s_axi_arvalid && s_axi_arready)
		begin
			cur_next.rvalid = 1'b1;
			cur_next.rresp = RESP_OKAY;
			if (csrc_decode(s_axi_araddr) == 2'b01)
				cur_next.rdata = {24'h000000, cur_reg.ctrl};
			else if (csrc_decode(s_axi_araddr) == 2'b10)
				cur_next.rdata = stat_word;
			else
			begin
				cur_next.rdata = 32'h0000_0000;
				cur_next.rresp = RESP_SLVERR;
			end
		end
		else if (cur_reg.rvalid && s_axi_rready)
			cur_next.rvalid = 1'b0;
	end

	// ======================================================
	// state register
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			cur_reg <= '0;
			cur_reg.s1 <= 7'h02;
			cur_reg.s2 <= 7'h02;
			// power on starts on the main source with the miss count cleared
			cur_reg.src <= SRC_MAIN;
			cur_reg.lvd_below <= 1'b1;
			cur_reg.seq <= SEQ_HOLD;
			cur_reg.pc <= RESET_VECTOR;
			cur_reg.nmi <= 1'b1;
			cur_reg.ctrl <= CTRL_RESET;
			cur_reg.bresp <= RESP_OKAY;
			cur_reg.rresp <= RESP_OKAY;
		end
		else
			cur_reg <= cur_next;
	end

	// ======================================================
	// outputs
	assign s_axi_awready = ~cur_reg.aw_ok & ~cur_reg.bvalid;
	assign s_axi_wready = ~cur_reg.w_ok & ~cur_reg.bvalid;
	assign s_axi_bvalid = cur_reg.bvalid;
	assign s_axi_bresp = cur_reg.bresp;
	assign s_axi_arready = ~cur_reg.rvalid;
	assign s_axi_rvalid = cur_reg.rvalid;
	assign s_axi_rdata = cur_reg.rdata;
	assign s_axi_rresp = cur_reg.rresp;
	// open-drain: only ever pulls low
	assign reset_pin_out = 1'b0;
	assign reset_pin_oe = cur_reg.pin_drive;
	assign main_osc_en = ~osc_off_eff;
	assign backup_low_freq_osc_run = guard_s & (cur_reg.src == SRC_BACKUP);
	assign internal_clock = cur_reg.tick;
	assign core_reset = (cur_reg.seq != SEQ_RUN);
	assign stack_clear = (cur_reg.seq != SEQ_RUN);
	assign vector_fetch = (cur_reg.seq == SEQ_FETCH);
	assign pc_value = cur_reg.pc;
	assign nmi_mode = cur_reg.nmi;
	assign io_pullup_inputs = (cur_reg.seq != SEQ_RUN);

endmodule : csrc_top

//--- tb/csrc_top_asserts.sv
`timescale 1ns/1ps
// ====
// port checker for reset sequencing and clock guard
module csrc_chk
	import csrc_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic guard_option,
	input wire logic lvd_option,
	input wire logic supply_high,
	input wire logic watchdog_reset,
	input wire logic return_from_interrupt,
	input wire logic reset_pin_in,
	input wire logic reset_pin_out,
	input wire logic reset_pin_oe,
	input wire logic main_osc_en,
	input wire logic backup_low_freq_osc_run,
	input wire logic internal_clock,
	input wire logic core_reset,
	input wire logic stack_clear,
	input wire logic vector_fetch,
	input wire logic [11:0] pc_value,
	input wire logic nmi_mode,
	input wire logic io_pullup_inputs
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	logic [7:0] gap_reg;
	// cycles since last main tick; backup hand-over is not spaced
	always_ff @(posedge aclk)
		if (!aresetn || backup_low_freq_osc_run)
			gap_reg <= 8'hFF;
		else if (internal_clock)
			gap_reg <= 8'h01;
		else if (gap_reg != 8'hFF)
			gap_reg <= gap_reg + 8'h01;
	wd_hold_a: assert property (watchdog_reset |=> core_reset && !vector_fetch)
		else $error("watchdog did not hold the core");
	hold_side_a: assert property (core_reset |-> stack_clear && io_pullup_inputs && nmi_mode)
		else $error("reset side effects missing");
	pc_vec_a: assert property (vector_fetch |-> core_reset && pc_value == RESET_VECTOR)
		else $error("fetch without reset vector");
	run_after_a: assert property ($fell(core_reset) |-> $past(vector_fetch))
		else $error("run entered without fetch");
	tick_gap_a: assert property (internal_clock && guard_option |-> gap_reg >= (supply_high ? GUARD_HI_CYC[7:0] : GUARD_LO_CYC[7:0]))
		else $error("guarded ticks too close");
	guard_bk_a: assert property (backup_low_freq_osc_run |-> guard_option)
		else $error("backup runs without guard");
	pin_lvd_a: assert property (reset_pin_oe |-> lvd_option && !reset_pin_out ##1 core_reset)
		else $error("pin pulled without low-voltage reset");
	osc_off_a: assert property (!guard_option |-> main_osc_en)
		else $error("oscillator off without guard");
	nmi_clr_a: assert property (return_from_interrupt && !core_reset && !watchdog_reset && reset_pin_in && $past(reset_pin_in, 2) && !lvd_option |=> !nmi_mode)
		else $error("return did not leave nmi mode");
	// main scenarios reached
	cover property (vector_fetch ##1 !vector_fetch);
	cover property ($rose(backup_low_freq_osc_run));
	cover property ($rose(reset_pin_oe));
endmodule : csrc_chk
bind csrc_top csrc_chk chk_u (.aclk, .aresetn, .guard_option, .lvd_option,
	.supply_high, .watchdog_reset, .return_from_interrupt, .reset_pin_in,
	.reset_pin_out, .reset_pin_oe, .main_osc_en, .backup_low_freq_osc_run,
	.internal_clock, .core_reset, .stack_clear, .vector_fetch, .pc_value,
	.nmi_mode, .io_pullup_inputs);

//--- tb/csrc_ext_model.sv
`timescale 1ns/1ps
// ====
// main oscillator and board reset network
module csrc_ext_model (
	input wire logic aclk,
	input wire logic osc_en,
	input wire logic [7:0] half_cyc,
	input wire logic board_rst_n,
	input wire logic pin_oe,
	output logic osc_out,
	output logic rst_pin
);
	logic [7:0] cnt_reg = 8'h00;
	logic ph_reg = 1'h0;
	// a disabled oscillator freezes, so its edges really go missing
	always_ff @(posedge aclk)
		if (!osc_en)
			cnt_reg <= 8'h00;
		else if (cnt_reg + 8'h01 >= half_cyc)
		begin
			cnt_reg <= 8'h00;
			ph_reg <= ~ph_reg;
		end
		else
			cnt_reg <= cnt_reg + 8'h01;
	// pin has a pull-up; board or device may pull it low
	assign osc_out = ph_reg;
	assign rst_pin = board_rst_n && !pin_oe;
endmodule : csrc_ext_model

//--- tb/tb_clock_safeguard_reset_control.sv
`timescale 1ns/1ps
// ====
// bench top
module tb_clock_safeguard_reset_control
	import csrc_pkg::*;
;
	logic aclk = 1'h0, aresetn = 1'h0, s_axi_awvalid = 1'h0;
	logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000, pc_value;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
	logic s_axi_rready = 1'h0, s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic s_axi_arready, s_axi_rvalid, main_osc_in, reset_pin_in;
	logic [1:0] s_axi_bresp, s_axi_rresp, rs;
	logic guard_option = 1'h0, lvd_option = 1'h0, supply_high = 1'h0;
	logic vdd_above_rising = 1'h1, vdd_above_falling = 1'h1;
	logic watchdog_reset = 1'h0, return_from_interrupt = 1'h0;
	logic board_rst_n = 1'h1, reset_pin_out, reset_pin_oe, main_osc_en;
	logic backup_low_freq_osc_run, internal_clock, core_reset, stack_clear;
	logic vector_fetch, nmi_mode, io_pullup_inputs;
	logic [7:0] v;
	int fails = 0, num_checks = 0, seed = 32'h1130, w, n;
	// free-running system clock
	initial forever #5 aclk = ~aclk;
	csrc_top dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .main_osc_in,
		.reset_pin_in, .reset_pin_out, .reset_pin_oe, .guard_option,
		.lvd_option, .supply_high, .vdd_above_rising, .vdd_above_falling,
		.watchdog_reset, .return_from_interrupt, .main_osc_en,
		.backup_low_freq_osc_run, .internal_clock, .core_reset, .stack_clear,
		.vector_fetch, .pc_value, .nmi_mode, .io_pullup_inputs);
	csrc_ext_model ext_u (.aclk, .osc_en(main_osc_en), .half_cyc(8'h01),
		.board_rst_n, .pin_oe(reset_pin_oe), .osc_out(main_osc_in),
		.rst_pin(reset_pin_in));
	// ====
	// helpers
	task automatic complete_run();
		$display("checks %0d fails %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : complete_run
	task automatic chk(input logic ok, input string m);
		num_checks++;
		if (ok !== 1'h1)
		begin
			fails++;
			$display("CHECK FAILED %0t %s", $time, m);
		end
	endtask : chk
	// bounded wait; a hang ends the run
	task automatic wait_for(ref logic s, input logic val);
		for (w = 0; w < 60000 && s !== val; w++)
			@(posedge aclk);
		if (s !== val)
		begin
			fails++;
			complete_run();
		end
	endtask : wait_for
	// done is local: the ready flags only change at the next update
	task automatic axw(input logic [11:0] a, input logic [31:0] d);
		bit done;
		done = 1'b0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		for (int i = 0; i < 50 && !done; i++)
		begin
			@(posedge aclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'h0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'h0;
			if (s_axi_bvalid)
			begin
				s_axi_bready <= 1'h0;
				rs = s_axi_bresp;
				done = 1'b1;
			end
		end
		// one edge between transfers so no strobe is set twice at once
		@(posedge aclk);
		chk(done && rs === RESP_OKAY, "write answer");
	endtask : axw
	task automatic axr(input logic [11:0] a);
		bit done;
		done = 1'b0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		for (int i = 0; i < 50 && !done; i++)
		begin
			@(posedge aclk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'h0;
			if (s_axi_rvalid)
			begin
				rd = s_axi_rdata;
				rs = s_axi_rresp;
				s_axi_rready <= 1'h0;
				done = 1'b1;
			end
		end
		@(posedge aclk);
		chk(done, "read answer");
	endtask : axr
	// two cycles per tick with the guard off; sync slack on top
	function automatic bit in_win(int t);
		return t >= 2 * int'(DELAY_CYCLES) - 2 && t <= 2 * int'(DELAY_CYCLES) + 8;
	endfunction : in_win
	task automatic run_seq(input bit dl);
		int t = 0, f = 0;
		while (vector_fetch !== 1'h1 && t < 60000)
		begin
			@(posedge aclk);
			t++;
		end
		while (vector_fetch === 1'h1 && f < 20)
		begin
			@(posedge aclk);
			f++;
		end
		if (dl)
			chk(in_win(t), "delay length");
		chk(f === 2 * int'(FETCH_CYCLES), "fetch length");
		chk(core_reset === 1'h0, "not running");
	endtask : run_seq
	// ====
	// main sequence
	initial
	begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'h1;
		@(posedge aclk);
		axr(CTRL_ADDR);
		chk(rd === 32'h40 && rs === RESP_OKAY, "ctrl reset value");
		axr(12'h000);
		chk(rs === RESP_SLVERR && rd === 32'h0, "unmapped read");
		chk(stack_clear === 1'h1 && io_pullup_inputs === 1'h1, "hold");
		chk(pc_value === RESET_VECTOR && nmi_mode === 1'h1, "vector");
		run_seq(1'h0);
		return_from_interrupt <= 1'h1;
		@(posedge aclk);
		return_from_interrupt <= 1'h0;
		repeat (2) @(posedge aclk);
		chk(nmi_mode === 1'h0, "nmi left");
		n = $random(seed);
		v = n[7:0] | 8'h04;
		axw(CTRL_ADDR, {24'h0, v});
		axr(CTRL_ADDR);
		chk(rd === {24'h0, v} && main_osc_en === 1'h1, "off ignored");
		// watchdog, then a second request in mid-delay
		watchdog_reset <= 1'h1;
		repeat (2 + n[10:8]) @(posedge aclk);
		chk(core_reset === 1'h1 && nmi_mode === 1'h1, "wd reset");
		watchdog_reset <= 1'h0;
		repeat (1000) @(posedge aclk);
		watchdog_reset <= 1'h1;
		@(posedge aclk);
		watchdog_reset <= 1'h0;
		run_seq(1'h1);
		axr(CTRL_ADDR);
		chk(rd === {24'h0, CTRL_RESET}, "ctrl reload");
		// short pin pulse is stretched
		board_rst_n <= 1'h0;
		repeat (5 + n[13:11]) @(posedge aclk);
		chk(core_reset === 1'h1 && io_pullup_inputs === 1'h1, "pin");
		board_rst_n <= 1'h1;
		run_seq(1'h1);
		// guard and low-voltage options on
		aresetn <= 1'h0;
		guard_option <= 1'h1;
		lvd_option <= 1'h1;
		vdd_above_rising <= 1'h0;
		vdd_above_falling <= 1'h0;
		repeat (16) @(posedge aclk);
		aresetn <= 1'h1;
		repeat (20) @(posedge aclk);
		chk(reset_pin_oe === 1'h1 && core_reset === 1'h1, "lvd");
		vdd_above_falling <= 1'h1;
		repeat (20) @(posedge aclk);
		chk(reset_pin_oe === 1'h1, "below rising");
		vdd_above_rising <= 1'h1;
		wait_for(core_reset, 1'h0);
		vdd_above_rising <= 1'h0;
		repeat (20) @(posedge aclk);
		chk(core_reset === 1'h0, "hysteresis");
		axw(CTRL_ADDR, 32'h44);
		chk(main_osc_en === 1'h0, "osc off");
		wait_for(backup_low_freq_osc_run, 1'h1);
		chk(w <= int'(MISS_CYC + BACKUP_CYC) + 8, "backup late");
		wait_for(internal_clock, 1'h1);
		@(posedge aclk);
		wait_for(internal_clock, 1'h1);
		chk(w + 1 === int'(BACKUP_CYC), "backup tick");
		axw(CTRL_ADDR, 32'h40);
		wait_for(backup_low_freq_osc_run, 1'h0);
		chk(w < 10, "backup stop");
		vdd_above_falling <= 1'h0;
		wait_for(reset_pin_oe, 1'h1);
		chk(w < 8, "drop reset");
		complete_run();
	end
endmodule : tb_clock_safeguard_reset_control
